// file: common/csd_map.vh
// Constants for the CPU clock slowdown divider: offsets, fields, resets.
// Assumes inclusion by the Wishbone-facing control block only.
`ifndef CSD_MAP_VH
`define CSD_MAP_VH

// Register byte address (single register block)
`define CSD_CTRL_ADDR 4'h0
// Field positions inside the control register
`define CSD_ROI_BIT 15
`define CSD_RATIO_HI 14
`define CSD_RATIO_LO 12
`define CSD_SLOW_BIT 11
`define CSD_PSC_HI 10
`define CSD_PSC_LO 8
// Reset values of fields
`define CSD_ROI_RST 1'h0
`define CSD_RATIO_RST 3'h3
`define CSD_SLOW_RST 1'h0
`define CSD_PSC_RST 3'h1
// Oscillator select codes that route the postscaler
`define CSD_OSC_FAST 3'h7
`define CSD_OSC_SLOW 3'h6
// Postscaler code whose divisor jumps to 256
`define CSD_PSC_MAX 3'h7

`endif

// file: hw/csd_divider.v
// Power-of-two clock enable divider: pulses once every 2^shift input cycles.
// Assumes a free-running clock and a synchronous reset on that clock.
`timescale 1ns/10ps

module csd_divider (
   input wire clk_i, // System clock
   input wire rst_i, // Sync reset, active high
   input wire restart_i, // Restart the count from zero
   input wire [3:0] shift_i, // Divide by 2^shift, 0..8
   output reg tick_o // One-cycle enable pulse
);

   reg [7:0] cnt_q; // Free-running count
   wire [7:0] mask; // Low bits that must be all ones
   wire hit; // Count reached end of period

   // Mask has shift_i ones at the bottom, all eight ones for shift_i of 8 or more
   assign mask = (shift_i >= 4'h8) ? 8'hFF : ((8'h01 << shift_i) - 8'h01);
   assign hit = ((cnt_q & mask) == mask);

   // Count and emit a tick at period end
   always @(posedge clk_i) begin
      if (rst_i || restart_i) begin
         cnt_q <= 8'h00;
         tick_o <= 1'b0;
      end else begin
         // Wrap at the period so a new shift starts cleanly
         cnt_q <= hit ? 8'h00 : cnt_q + 8'h01;
         tick_o <= hit;
      end
   end

endmodule

// file: hw/csd_ctrl.v
// Clock divider control: Wishbone register, CPU slowdown enable, fast-RC postscaler.
// Assumes a Wishbone classic master and a synchronous interrupt pulse on clk_i.
`timescale 1ns/10ps
`include "csd_map.vh"

module csd_ctrl (
   input wire clk_i, // System clock, 100 MHz
   input wire rst_i, // Sync reset, active high
   // Wishbone classic slave
   input wire wb_cyc_i, // Bus cycle
   input wire wb_stb_i, // Strobe
   input wire wb_we_i, // Write enable
   input wire [3:0] wb_adr_i, // Byte address
   input wire [3:0] wb_sel_i, // Byte lanes
   input wire [31:0] wb_dat_i, // Write data
   output reg [31:0] wb_dat_o, // Read data
   output reg wb_ack_o, // Acknowledge
   output reg wb_err_o, // Unmapped address
   // Interrupt logic and oscillator control
   input wire irq_event_i, // Interrupt taken, one-cycle pulse
   input wire [2:0] current_osc_select_i, // Current oscillator code
   input wire fast_rc_clk_i, // Fast RC source clock, async
   // Clock gating outputs
   output reg cpu_clk_en_o, // CPU clock enable pulse
   output wire periph_clk_en_o, // Peripheral clock enable
   output reg fast_rc_div_o, // Postscaled fast RC, as a level
   output reg [8:0] fast_rc_divisor_o, // Active postscale divisor
   output reg fast_rc_route_o // Postscaler output valid for source
);

   reg recover_on_irq_q; // Interrupt recovery enable
   reg [2:0] ratio_q; // CPU ratio code
   reg slowdown_enable_q; // Slowdown mode on
   reg [2:0] fast_rc_postscale_q; // Postscaler code
   wire [15:0] clock_divider_control; // Register read image
   wire hit; // Address matches the register
   wire req; // Live request, not yet answered
   wire wr_hi; // Write touching the upper byte
   wire cpu_tick; // Divider tick
   reg [3:0] cpu_shift; // Effective CPU shift
   reg [2:0] osc_s1_q; // Oscillator select sync stage 1
   reg [2:0] osc_s2_q; // Oscillator select sync stage 2
   reg [7:0] rc_cnt_q; // Fast RC postscale counter
   reg [2:0] rc_s1_q; // Fast RC pin sync stages
   wire rc_rise; // Synced fast RC rising edge
   reg [8:0] rc_div; // Decoded divisor
   reg [7:0] rc_mask; // Counter bits for toggle

   assign clock_divider_control = {recover_on_irq_q, ratio_q, slowdown_enable_q,
      fast_rc_postscale_q, 8'h00};
   assign hit = (wb_adr_i == `CSD_CTRL_ADDR);
   // Only new requests; the ack cycle is never answered twice
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   assign wr_hi = req && hit && wb_we_i && wb_sel_i[1];

   // Wishbone answer one cycle after the request
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= req && hit;
         // Unmapped address answers with an error, not silence
         wb_err_o <= req && !hit;
         if (req && hit && !wb_we_i) begin
            wb_dat_o <= {16'h0000, clock_divider_control};
         end else begin
            wb_dat_o <= 32'h00000000;
         end
      end
   end

   // Register fields; interrupt recovery wins over a same-cycle write
   always @(posedge clk_i) begin
      if (rst_i) begin
         recover_on_irq_q <= `CSD_ROI_RST;
         ratio_q <= `CSD_RATIO_RST;
         slowdown_enable_q <= `CSD_SLOW_RST;
         fast_rc_postscale_q <= `CSD_PSC_RST;
      end else begin
         if (wr_hi) begin
            recover_on_irq_q <= wb_dat_i[`CSD_ROI_BIT];
            ratio_q <= wb_dat_i[`CSD_RATIO_HI:`CSD_RATIO_LO];
            slowdown_enable_q <= wb_dat_i[`CSD_SLOW_BIT];
            fast_rc_postscale_q <= wb_dat_i[`CSD_PSC_HI:`CSD_PSC_LO];
         end
         if (irq_event_i && recover_on_irq_q) begin
            slowdown_enable_q <= 1'b0;
            ratio_q <= 3'h0;
         end
         // no effect otherwise: fields simply hold
      end
   end

   always @* begin
      if (slowdown_enable_q) begin
         cpu_shift = {1'b0, ratio_q};
      end else begin
         cpu_shift = 4'h0;
      end
   end

   // CPU enable divider
   csd_divider u_cpu_div (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .restart_i(1'b0),
      .shift_i(cpu_shift),
      .tick_o(cpu_tick)
   );

   // CPU enable; at 1:1 every cycle, no divider latency
   always @* begin
      if (cpu_shift == 4'h0) begin
         cpu_clk_en_o = 1'b1;
      end else begin
         cpu_clk_en_o = cpu_tick;
      end
   end

   assign periph_clk_en_o = 1'b1;

   // Oscillator select comes from another unit; two-stage sync
   always @(posedge clk_i) begin
      if (rst_i) begin
         osc_s1_q <= 3'h0;
         osc_s2_q <= 3'h0;
      end else begin
         osc_s1_q <= current_osc_select_i;
         osc_s2_q <= osc_s1_q;
      end
   end

   // Divisor table: 2^code, except top code gives 256
   always @* begin
      if (fast_rc_postscale_q == `CSD_PSC_MAX) begin
         rc_div = 9'h100;
      end else begin
         rc_div = 9'h001 << fast_rc_postscale_q;
      end
      rc_mask = rc_div[8] ? 8'hFF : (rc_div[7:0] - 8'h01);
   end

   // Fast RC pin sync; third stage only feeds the edge detector
   always @(posedge clk_i) begin
      if (rst_i) begin
         rc_s1_q <= 3'h0;
      end else begin
         rc_s1_q <= {rc_s1_q[1:0], fast_rc_clk_i};
      end
   end
   assign rc_rise = rc_s1_q[1] && !rc_s1_q[2];

   // fast RC source postscale
   // Limitation: source edges are sampled, so source must be under half clk_i
   always @(posedge clk_i) begin
      if (rst_i) begin
         rc_cnt_q <= 8'h00;
         fast_rc_div_o <= 1'b0;
         fast_rc_divisor_o <= 9'h002;
         fast_rc_route_o <= 1'b0;
      end else begin
         fast_rc_divisor_o <= rc_div;
         fast_rc_route_o <= (osc_s2_q == `CSD_OSC_FAST) || (osc_s2_q == `CSD_OSC_SLOW);
         if (!((osc_s2_q == `CSD_OSC_FAST) || (osc_s2_q == `CSD_OSC_SLOW))) begin
            rc_cnt_q <= 8'h00;
            fast_rc_div_o <= 1'b0;
         end else if (rc_div == 9'h001) begin
            // Divide by one follows the source directly
            fast_rc_div_o <= rc_s1_q[1];
         end else if (rc_rise) begin
            // Toggle at half period, i.e. every divisor/2 source edges
            if ((rc_cnt_q & (rc_mask >> 1)) == (rc_mask >> 1)) begin
               fast_rc_div_o <= !fast_rc_div_o;
            end
            rc_cnt_q <= (rc_cnt_q == rc_mask) ? 8'h00 : rc_cnt_q + 8'h01;
         end
      end
   end

endmodule

// file: testbench/csd_checker.sv
// Checker on csd_ctrl ports: bus answers, recovery, clock enables.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module csd_checker (
   input wire clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o,
   input wire irq_event_i, cpu_clk_en_o, periph_clk_en_o, fast_rc_route_o,
   input wire [3:0] wb_adr_i, wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire [2:0] current_osc_select_i,
   input wire [8:0] fast_rc_divisor_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire rq = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o; // Request taken
   wire wr = rq & wb_we_i & wb_sel_i[1] & (wb_adr_i == 4'h0); // Control byte write
   reg roi_q, slow_q; // Shadow bits
   // Recovery beats a same-cycle write
   always @(posedge clk_i) begin
      if (wr | rst_i) roi_q <= wb_dat_i[15] & ~rst_i;
      if (rst_i | (irq_event_i & roi_q)) slow_q <= 1'b0;
      else if (wr) slow_q <= wb_dat_i[11];
   end
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   chk_ack_map: assert property (rq && wb_adr_i == 4'h0 |=> wb_ack_o && !wb_err_o)
      else $error("no ack");
   chk_err_unmap: assert property (rq && wb_adr_i != 4'h0 |=> wb_err_o && !wb_ack_o)
      else $error("no err");
   chk_irq_full: assert property (irq_event_i && roi_q |=> cpu_clk_en_o [*2])
      else $error("no recovery");
   chk_slow_off: assert property (!slow_q && !$past(slow_q) |-> cpu_clk_en_o)
      else $error("CPU divided");
   chk_periph_full: assert property (periph_clk_en_o) else $error("periph gated");
   chk_div_pow: assert property ($onehot(fast_rc_divisor_o) && !fast_rc_divisor_o[7])
      else $error("bad divisor");
   chk_route_on: assert property ((current_osc_select_i == 3'h7) [*5] |-> fast_rc_route_o)
      else $error("not routed");
   cover property (irq_event_i && roi_q);
   cover property (wb_err_o);
   cover property (slow_q && !cpu_clk_en_o);
endmodule
bind csd_ctrl csd_checker chk (.*);

// file: testbench/csd_core_model.sv
// Interrupt logic and fast RC source beside csd_ctrl.
// Assumes fire_i changes just after clk_i edges.
`timescale 1ns/10ps
module csd_core_model (
   input wire clk_i, rst_i, fire_i,
   output reg irq_event_o, fast_rc_clk_o
);
   // One-cycle pulse per request, none in reset
   always @(posedge clk_i) irq_event_o <= fire_i & ~rst_i;
   // Free 8 MHz source, unrelated in phase; the forever loop below is its only driver
   initial begin
      fast_rc_clk_o = 1'b0;
      forever #62.5 fast_rc_clk_o = ~fast_rc_clk_o;
   end
endmodule

// file: testbench/tb_csd_ctrl.sv
// Bench for csd_ctrl: register, ratios, recovery, postscaler.
// Assumes the bound checker and csd_core_model as interrupt source.
`timescale 1ns/10ps
module tb_csd_ctrl;
   reg clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, fire;
   reg [3:0] wb_adr_i, wb_sel_i;
   reg [31:0] wb_dat_i;
   reg [2:0] current_osc_select_i;
   reg [8:0] dv; // Expected divisor
   wire [31:0] wb_dat_o;
   wire [8:0] fast_rc_divisor_o;
   wire wb_ack_o, wb_err_o, irq_event_i, fast_rc_clk_i, cpu_clk_en_o;
   wire periph_clk_en_o, fast_rc_div_o, fast_rc_route_o;
   reg [32:0] exp_q[$]; // Expected {err, data}
   integer num_errors = 0, checks = 0, seed = 12919, tmo = 0, n, i, r;
   csd_ctrl dut (.*);
   csd_core_model core (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire),
      .irq_event_o(irq_event_i), .fast_rc_clk_o(fast_rc_clk_i));
   task check(input [32:0] g, input [32:0] e);
      checks = checks + 1;
      if (g !== e) begin
         num_errors = num_errors + 1;
         $display("Error %0t: got %h want %h", $time, g, e);
      end
   endtask
   task end_sim;
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Held until ack or err; answer noted first
   task wb(input [3:0] a, input w, input [3:0] s, input [31:0] d, input [32:0] e);
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
      {wb_adr_i, wb_sel_i, wb_dat_i} <= {a, s, d};
      exp_q.push_back(e);
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) @(posedge clk_i);
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask
   // Window of 256 cycles, so any phase gives the same count
   task count(input [31:0] e);
      repeat (260) @(posedge clk_i);
      n = 0;
      repeat (256) @(posedge clk_i) n = n + cpu_clk_en_o;
      check({1'b0, n}, {1'b0, e});
   endtask
   task pulse;
      @(posedge clk_i) fire <= 1'b1;
      @(posedge clk_i) fire <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask
   // Answers leave the queue in order; cycle limit
   always @(posedge clk_i) begin
      tmo <= tmo + 1;
      if (wb_ack_o === 1'b1 || wb_err_o === 1'b1)
         check({wb_err_o, wb_dat_o}, exp_q.pop_front());
      if (tmo == 20000) begin
         num_errors = num_errors + 1;
         end_sim;
      end
   end
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, fire} = 5'h10;
      {wb_adr_i, wb_sel_i, wb_dat_i} = 40'h0;
      current_osc_select_i = 3'h7;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(4'h0, 1'b0, 4'hF, 32'h0, 33'h3100);
      wb(4'h0, 1'b1, 4'hF, 32'hFFFFFFFF, 33'h0);
      wb(4'h0, 1'b1, 4'hD, 32'h0, 33'h0);
      wb(4'h0, 1'b0, 4'hF, 32'h0, 33'hFF00);
      repeat (4) begin
         r = $random(seed);
         wb(r[3:0] | 4'h1, r[4], 4'hF, r, 33'h100000000);
         wb(4'h0, 1'b1, 4'h2, r, 33'h0);
         wb(4'h0, 1'b0, 4'hF, 32'h0, {17'h0, r[15:8], 8'h00});
      end
      // Every ratio with slowdown on, then ratio 7 with it off
      for (i = 0; i < 9; i = i + 1) begin
         wb(4'h0, 1'b1, 4'h2, {17'h0, i[3] ? 7'h71 : {i[2:0], 4'h9}, 8'h00}, 33'h0);
         count(i[3] ? 256 : 256 >> i);
      end
      wb(4'h0, 1'b1, 4'h2, 32'h3900, 33'h0);
      pulse;
      wb(4'h0, 1'b0, 4'hF, 32'h0, 33'h3900);
      wb(4'h0, 1'b1, 4'h2, 32'hB900, 33'h0);
      pulse;
      wb(4'h0, 1'b0, 4'hF, 32'h0, 33'h8100);
      count(256);
      for (i = 0; i < 16; i = i + 1) begin
         current_osc_select_i <= i[3] ? 3'h6 : 3'h7;
         wb(4'h0, 1'b1, 4'h2, {21'h0, i[2:0], 8'h00}, 33'h0);
         dv = (i[2:0] == 3'h7) ? 9'h100 : 9'h1 << i[2:0];
         repeat (6) @(posedge clk_i);
         check({23'h0, fast_rc_route_o, fast_rc_divisor_o}, {24'h1, dv});
      end
      current_osc_select_i <= 3'h3;
      repeat (6) @(posedge clk_i);
      check({31'h0, fast_rc_route_o, fast_rc_div_o}, 33'h0);
      end_sim;
   end
endmodule
